// *** shared/lthr_pkg.sv ***
package lthr_pkg;
	// Clock and the common one second time base.
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned TICK_PERIOD_S = 1;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_S * CLK_HZ;
	localparam int TICK_W = 28;
	localparam int SEC_W = 24;

	// Sequence times in seconds.
	localparam logic [23:0] START_DELAY_S = 24'd150;
	localparam logic [23:0] VALVE_BLANK_S = 24'd260;
	localparam logic [23:0] PUMP_OVERRUN_S = 24'd150;
	localparam logic [23:0] FLOW_TRIP_S = 24'd60;
	localparam logic [23:0] SECS_PER_MIN = 24'd60;

	// Temperatures are signed tenths of a kelvin; 3 K re-arm band.
	localparam logic signed [16:0] TEMP_HYST = 17'sd30;
	localparam logic [7:0] PCT_MAX = 8'h64;
	localparam logic [7:0] PCT_ZERO = 8'h00;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SPREAD = 8'h04;
	localparam logic [7:0] ADDR_PUMP_LIM = 8'h08;
	localparam logic [7:0] ADDR_START_THR = 8'h0c;
	localparam logic [7:0] ADDR_TEMP_LIM = 8'h10;
	localparam logic [7:0] ADDR_INT_SET = 8'h14;
	localparam logic [7:0] ADDR_PRESS = 8'h18;
	localparam logic [7:0] ADDR_HEAT = 8'h1c;
	localparam logic [7:0] ADDR_LOCK = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;

	// Reset values.
	localparam logic [31:0] RST_CTRL = 32'h0000_0002;
	localparam logic [31:0] RST_SPREAD = 32'h0000_0046;
	localparam logic [31:0] RST_PUMP_LIM = 32'h0000_6414;
	localparam logic [31:0] RST_START_THR = 32'h0000_000a;
	localparam logic [31:0] RST_TEMP_LIM = 32'h012c_0190;
	localparam logic [31:0] RST_INT_SET = 32'h0000_015e;
	localparam logic [31:0] RST_PRESS = 32'h0005_0078;
	localparam logic [31:0] RST_HEAT = 32'h000a_0032;
	localparam logic [31:0] RST_LOCK = 32'h0000_000f;

	// Control register bits.
	localparam int CTRL_OFF_BIT = 0;
	localparam int CTRL_EXTSEL_BIT = 1;
	localparam int CTRL_PRESS_BIT = 2;

	// Synchronised pin inputs.
	localparam int SYNC_W = 10;
	localparam int PIN_REQ = 0;
	localparam int PIN_PUMP_OK = 1;
	localparam int PIN_FLOW_OK = 2;
	localparam int PIN_AT_OPEN = 3;
	localparam int PIN_AT_CLOSED = 4;
	localparam int PIN_PWR_OK = 5;
	localparam int PIN_BREAK_LO = 6;
	localparam int PIN_BREAK_HI = 9;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_ACTIVE} lthr_seq_e;

	typedef struct packed {
		logic signed [15:0] waterIn;
		logic signed [15:0] waterOut;
		logic signed [15:0] gasIn;
		logic signed [15:0] gasOut;
	} lthr_temps_s;

	typedef struct packed {
		logic pumpFault;
		logic valveMismatch;
		logic flowLoss;
		logic lowPressure;
		logic overTemp;
		logic noHeatPower;
		logic wireBreak;
	} lthr_alarm_s;
endpackage

// *** core/lthr_sync.sv ***
`timescale 1ns/1ps
module lthr_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Pins and filtered levels.
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] clean
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// A change is taken only once the second and third stages agree.
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				stage1[i] <= 1'b0;
				stage2[i] <= 1'b0;
				stage3[i] <= 1'b0;
				clean[i] <= 1'b0;
			end else begin
				stage1[i] <= pinIn[i];
				stage2[i] <= stage1[i];
				stage3[i] <= stage2[i];
				if (stage2[i] == stage3[i]) begin
					clean[i] <= stage3[i];
				end
			end
		end
	end
endmodule

// *** core/lthr_seq.sv ***
`timescale 1ns/1ps
module lthr_seq #(
	parameter int unsigned TICK_CYCLES = lthr_pkg::TICK_CYCLES
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Avalon-MM slave.
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Field pins, asynchronous.
	input wire logic [lthr_pkg::SYNC_W-1:0] pins,
	// Digitised analogue values.
	input wire lthr_pkg::lthr_temps_s temps,
	input wire logic [7:0] externalPower,
	input wire logic [15:0] waterPressure,
	// Actuators and alarms.
	output logic pumpOn,
	output logic [7:0] pumpSpeed,
	output logic valveOpen,
	output lthr_pkg::lthr_alarm_s alarms
);
	logic [lthr_pkg::SYNC_W-1:0] pinLvl;
	logic [31:0] ctrl, spreadSet, pumpLim, startThr, tempLim;
	logic [31:0] intSet, pressCfg, heatCfg, lockCfg;
	logic busAck;
	logic [lthr_pkg::TICK_W-1:0] tickCnt;
	logic tick;
	lthr_pkg::lthr_seq_e seqState;
	logic [lthr_pkg::SEC_W-1:0] startSec, overrunSec, blankSec;
	logic [lthr_pkg::SEC_W-1:0] flowSec, pressSec, heatSec, lockSec;
	logic [7:0] powerSignal, intPower, next_powerSignal, next_pumpSpeed;
	logic calcEnable, powerValid, pumpDemand, forceClose, next_valveOpen;
	logic flowTrip, pressTrip, tempTrip, lockout, mismatch;
	logic heatShort, sensorBroken;
	logic signed [16:0] waterSpread, gasSpread, flowMax, returnMax;

	lthr_sync #(.W(lthr_pkg::SYNC_W)) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pinIn(pins),
		.clean(pinLvl)
	);

	////////////////////////////////////////////////////////////////////////
	// Register bus: one wait state, so read data always come from a flop.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction

	assign avs_waitrequest = (avs_read | avs_write) & ~busAck;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busAck <= 1'b0;
		end else begin
			busAck <= (avs_read | avs_write) & ~busAck;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= lthr_pkg::RST_CTRL;
			spreadSet <= lthr_pkg::RST_SPREAD;
			pumpLim <= lthr_pkg::RST_PUMP_LIM;
			startThr <= lthr_pkg::RST_START_THR;
			tempLim <= lthr_pkg::RST_TEMP_LIM;
			intSet <= lthr_pkg::RST_INT_SET;
			pressCfg <= lthr_pkg::RST_PRESS;
			heatCfg <= lthr_pkg::RST_HEAT;
			lockCfg <= lthr_pkg::RST_LOCK;
		end else if (avs_write && busAck) begin
			unique case (avs_address)
				lthr_pkg::ADDR_CTRL: ctrl <= merge(ctrl, avs_writedata, avs_byteenable);
				lthr_pkg::ADDR_SPREAD: spreadSet <= merge(spreadSet, avs_writedata, avs_byteenable);
				lthr_pkg::ADDR_PUMP_LIM: pumpLim <= merge(pumpLim, avs_writedata, avs_byteenable);
				lthr_pkg::ADDR_START_THR: startThr <= merge(startThr, avs_writedata, avs_byteenable);
				lthr_pkg::ADDR_TEMP_LIM: tempLim <= merge(tempLim, avs_writedata, avs_byteenable);
				lthr_pkg::ADDR_INT_SET: intSet <= merge(intSet, avs_writedata, avs_byteenable);
				lthr_pkg::ADDR_PRESS: pressCfg <= merge(pressCfg, avs_writedata, avs_byteenable);
				lthr_pkg::ADDR_HEAT: heatCfg <= merge(heatCfg, avs_writedata, avs_byteenable);
				lthr_pkg::ADDR_LOCK: lockCfg <= merge(lockCfg, avs_writedata, avs_byteenable);
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= '0;
		end else if (avs_read && !busAck) begin
			unique case (avs_address)
				lthr_pkg::ADDR_CTRL: avs_readdata <= {29'h0, ctrl[2:0]};
				lthr_pkg::ADDR_SPREAD: avs_readdata <= {16'h0, spreadSet[15:0]};
				lthr_pkg::ADDR_PUMP_LIM: avs_readdata <= {16'h0, pumpLim[15:0]};
				lthr_pkg::ADDR_START_THR: avs_readdata <= {24'h0, startThr[7:0]};
				lthr_pkg::ADDR_TEMP_LIM: avs_readdata <= tempLim;
				lthr_pkg::ADDR_INT_SET: avs_readdata <= {16'h0, intSet[15:0]};
				lthr_pkg::ADDR_PRESS: avs_readdata <= pressCfg;
				lthr_pkg::ADDR_HEAT: avs_readdata <= heatCfg;
				lthr_pkg::ADDR_LOCK: avs_readdata <= {16'h0, lockCfg[15:0]};
				lthr_pkg::ADDR_STATUS: avs_readdata <= {4'h0, seqState, valveOpen,
					pumpOn, 1'b0, alarms, powerSignal, pumpSpeed};
				default: avs_readdata <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One-second time base shared by every delay.
	assign tick = (tickCnt == lthr_pkg::TICK_W'(TICK_CYCLES - 1));

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tickCnt <= '0;
		end else if (tick) begin
			tickCnt <= '0;
		end else begin
			tickCnt <= tickCnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Request sequencing and power signal.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			seqState <= lthr_pkg::SEQ_IDLE;
			startSec <= '0;
		end else if (!pinLvl[lthr_pkg::PIN_REQ]) begin
			seqState <= lthr_pkg::SEQ_IDLE;
			startSec <= '0;
		end else begin
			unique case (seqState)
				lthr_pkg::SEQ_IDLE: seqState <= lthr_pkg::SEQ_DELAY;
				lthr_pkg::SEQ_DELAY: begin
					if (startSec >= lthr_pkg::START_DELAY_S) begin
						seqState <= lthr_pkg::SEQ_ACTIVE;
					end else if (tick) begin
						startSec <= startSec + 1'b1;
					end
				end
				lthr_pkg::SEQ_ACTIVE: ;
			endcase
		end
	end

	assign calcEnable = (seqState == lthr_pkg::SEQ_ACTIVE)
		&& !ctrl[lthr_pkg::CTRL_OFF_BIT] && !lockout;
	assign sensorBroken = |pinLvl[lthr_pkg::PIN_BREAK_HI:lthr_pkg::PIN_BREAK_LO];
	// Internal calculation needs intact water sensors; external its own flag.
	assign powerValid = ctrl[lthr_pkg::CTRL_EXTSEL_BIT] ?
		pinLvl[lthr_pkg::PIN_PWR_OK] : !sensorBroken;

	// Internal demand: one percent per tenth kelvin the outlet lies below set.
	always_comb begin
		logic signed [16:0] gap;
		gap = 17'(signed'(intSet[15:0])) - 17'(temps.waterOut);
		if (gap <= 0) begin
			intPower = lthr_pkg::PCT_ZERO;
		end else if (gap >= 17'(lthr_pkg::PCT_MAX)) begin
			intPower = lthr_pkg::PCT_MAX;
		end else begin
			intPower = gap[7:0];
		end
	end

	always_comb begin
		next_powerSignal = lthr_pkg::PCT_ZERO;
		if (calcEnable && powerValid) begin
			next_powerSignal = ctrl[lthr_pkg::CTRL_EXTSEL_BIT] ?
				externalPower : intPower;
			if (next_powerSignal > lthr_pkg::PCT_MAX) begin
				next_powerSignal = lthr_pkg::PCT_MAX;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			powerSignal <= lthr_pkg::PCT_ZERO;
		end else begin
			powerSignal <= next_powerSignal;
		end
	end

	assign pumpDemand = calcEnable && powerValid
		&& (powerSignal >= startThr[7:0]);

	////////////////////////////////////////////////////////////////////////
	// Pump run, overrun and speed.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			overrunSec <= '0;
			pumpOn <= 1'b0;
		end else begin
			if (pumpDemand) begin
				overrunSec <= lthr_pkg::PUMP_OVERRUN_S;
			end else if (tick && overrunSec != '0) begin
				overrunSec <= overrunSec - 1'b1;
			end
			// The pump fault input is deliberately not part of this term.
			pumpOn <= pumpDemand || (overrunSec != '0);
		end
	end

	assign waterSpread = 17'(temps.waterOut) - 17'(temps.waterIn);

	always_comb begin
		next_pumpSpeed = pumpSpeed;
		if (!pumpOn) begin
			next_pumpSpeed = pumpLim[7:0];
		end else begin
			if (tick && waterSpread < 17'(signed'(spreadSet[15:0]))) begin
				next_pumpSpeed = pumpSpeed - 1'b1;
			end else if (tick && waterSpread > 17'(signed'(spreadSet[15:0]))) begin
				next_pumpSpeed = pumpSpeed + 1'b1;
			end
			if (next_pumpSpeed > pumpLim[15:8] || next_pumpSpeed > lthr_pkg::PCT_MAX) begin
				next_pumpSpeed = (pumpLim[15:8] > lthr_pkg::PCT_MAX) ?
					lthr_pkg::PCT_MAX : pumpLim[15:8];
			end
			if (next_pumpSpeed < pumpLim[7:0] || pumpSpeed == lthr_pkg::PCT_ZERO) begin
				next_pumpSpeed = pumpLim[7:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pumpSpeed <= lthr_pkg::RST_PUMP_LIM[7:0];
		end else begin
			pumpSpeed <= next_pumpSpeed;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Water circuit monitors that force the valve shut.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			flowSec <= '0;
		end else if (pinLvl[lthr_pkg::PIN_FLOW_OK]) begin
			flowSec <= '0;
		end else if (tick && flowSec < lthr_pkg::FLOW_TRIP_S) begin
			flowSec <= flowSec + 1'b1;
		end
	end
	assign flowTrip = (flowSec >= lthr_pkg::FLOW_TRIP_S);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pressSec <= '0;
		end else if (!ctrl[lthr_pkg::CTRL_PRESS_BIT] || waterPressure >= pressCfg[15:0]) begin
			pressSec <= '0;
		end else if (tick && !pressTrip) begin
			pressSec <= pressSec + 1'b1;
		end
	end
	assign pressTrip = ctrl[lthr_pkg::CTRL_PRESS_BIT] &&
		(pressSec >= lthr_pkg::SEC_W'(pressCfg[31:16] * lthr_pkg::SECS_PER_MIN));

	assign flowMax = 17'(signed'(tempLim[15:0]));
	assign returnMax = 17'(signed'(tempLim[31:16]));

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tempTrip <= 1'b0;
		end else if (17'(temps.waterOut) > flowMax || 17'(temps.waterIn) > returnMax) begin
			tempTrip <= 1'b1;
		end else if (17'(temps.waterOut) <= flowMax - lthr_pkg::TEMP_HYST
			&& 17'(temps.waterIn) <= returnMax - lthr_pkg::TEMP_HYST) begin
			tempTrip <= 1'b0;
		end
	end

	assign forceClose = flowTrip || pressTrip || tempTrip;

	////////////////////////////////////////////////////////////////////////
	// Heating power check with delay and lockout.
	assign gasSpread = 17'(temps.gasIn) - 17'(temps.gasOut);
	assign heatShort = (gasSpread < 17'(signed'(heatCfg[15:0])))
		|| (temps.waterIn >= temps.gasIn);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			heatSec <= '0;
			lockSec <= '0;
		end else if (lockout) begin
			heatSec <= '0;
			if (tick) begin
				lockSec <= lockSec - 1'b1;
			end
		end else if (!pumpDemand || !heatShort) begin
			heatSec <= '0;
		end else if (heatSec >= lthr_pkg::SEC_W'(heatCfg[31:16] * lthr_pkg::SECS_PER_MIN)) begin
			lockSec <= lthr_pkg::SEC_W'(lockCfg[15:0] * lthr_pkg::SECS_PER_MIN);
			heatSec <= '0;
		end else if (tick) begin
			heatSec <= heatSec + 1'b1;
		end
	end
	assign lockout = (lockSec != '0);

	////////////////////////////////////////////////////////////////////////
	// Hot gas valve and its feedback.
	assign next_valveOpen = pumpDemand && pumpOn
		&& pinLvl[lthr_pkg::PIN_PUMP_OK] && !forceClose;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			valveOpen <= 1'b0;
			blankSec <= '0;
		end else begin
			valveOpen <= next_valveOpen;
			if (next_valveOpen != valveOpen) begin
				blankSec <= lthr_pkg::VALVE_BLANK_S;
			end else if (tick && blankSec != '0) begin
				blankSec <= blankSec - 1'b1;
			end
		end
	end

	assign mismatch = valveOpen ?
		!(pinLvl[lthr_pkg::PIN_AT_OPEN] && !pinLvl[lthr_pkg::PIN_AT_CLOSED]) :
		!(pinLvl[lthr_pkg::PIN_AT_CLOSED] && !pinLvl[lthr_pkg::PIN_AT_OPEN]);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			alarms <= '0;
		end else begin
			alarms.pumpFault <= !pinLvl[lthr_pkg::PIN_PUMP_OK];
			alarms.valveMismatch <= mismatch && blankSec == '0
				&& next_valveOpen == valveOpen;
			alarms.flowLoss <= flowTrip;
			alarms.lowPressure <= pressTrip;
			alarms.overTemp <= tempTrip;
			alarms.noHeatPower <= lockout;
			alarms.wireBreak <= sensorBroken;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_demandDrop;
		$fell(pumpDemand);
	endsequence

	sequence s_overrunHold;
		pumpOn [*8];
	endsequence

	a_valve_needs_pump:
		assert property (valveOpen |-> pumpOn && $past(pinLvl[lthr_pkg::PIN_PUMP_OK]))
		else $error("valve open without healthy running pump");
	a_off_zero_power:
		assert property (ctrl[lthr_pkg::CTRL_OFF_BIT] |=> powerSignal == lthr_pkg::PCT_ZERO)
		else $error("power signal while off button set");
	a_start_delay:
		assert property (seqState != lthr_pkg::SEQ_ACTIVE |=> powerSignal == lthr_pkg::PCT_ZERO)
		else $error("power signal before start delay");
	a_pump_start:
		assert property (pumpDemand |=> pumpOn)
		else $error("pump not started on demand");
	a_speed_range:
		assert property (pumpOn && $stable(pumpLim) |=> pumpSpeed <= lthr_pkg::PCT_MAX
			&& pumpSpeed >= $past(pumpLim[7:0]))
		else $error("pump speed outside limits");
	a_force_close:
		assert property (forceClose |=> !valveOpen)
		else $error("valve open while a monitor trips");
	a_monitor_pump:
		assert property (pumpDemand && forceClose |=> pumpOn)
		else $error("monitor closure stopped the pump");
	a_fault_pump:
		assert property (pumpDemand && !pinLvl[lthr_pkg::PIN_PUMP_OK] |=> pumpOn)
		else $error("pump fault stopped the pump");
	a_valve_first:
		assert property (s_demandDrop |=> !valveOpen)
		else $error("valve still open after deactivation");
	a_pump_overrun:
		assert property (s_demandDrop |=> s_overrunHold)
		else $error("pump stopped without overrun");
	a_mismatch_blank:
		assert property ($changed(valveOpen) |-> !alarms.valveMismatch ##1 !alarms.valveMismatch)
		else $error("mismatch alarm during valve travel");
	a_lockout_zero:
		assert property (lockout |=> powerSignal == lthr_pkg::PCT_ZERO)
		else $error("power signal during lockout");
endmodule

// *** verif/lthr_field_model.sv ***
`timescale 1ns/1ps
module lthr_field_model #(
	parameter int TRAVEL = 20
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Commands from the controller and from the bench.
	input wire logic valveOpen,
	input wire logic pumpHealthy,
	input wire logic flowHealthy,
	// Field feedback.
	output logic pumpOk,
	output logic flowOk,
	output logic atOpen,
	output logic atClosed
);
	int travel;
	logic lastCmd;

	assign pumpOk = pumpHealthy;
	assign flowOk = flowHealthy;

	// Both end switches are open while the actuator travels.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			travel <= 0;
			lastCmd <= 1'b0;
			atOpen <= 1'b0;
			atClosed <= 1'b1;
		end else if (valveOpen !== lastCmd) begin
			lastCmd <= valveOpen;
			travel <= TRAVEL;
			atOpen <= 1'b0;
			atClosed <= 1'b0;
		end else if (travel > 0) begin
			travel <= travel - 1;
		end else begin
			atOpen <= lastCmd;
			atClosed <= !lastCmd;
		end
	end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	localparam int TC = 4;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic req = 1'b0;
	logic pwrOk = 1'b1;
	logic [3:0] brk = 4'h0;
	logic pHealthy = 1'b1;
	logic fHealthy = 1'b1;
	logic fbSwap = 1'b0;
	logic pumpOk, flowOk, atOpen, atClosed;
	logic [9:0] pins;
	lthr_pkg::lthr_temps_s temps = {16'sd200, 16'sd250, 16'sd700, 16'sd500};
	logic [7:0] extPower = 8'h32;
	logic [15:0] press = 16'h00c8;
	logic pumpOn, valveOpen;
	logic [7:0] pumpSpeed;
	lthr_pkg::lthr_alarm_s alarms;
	int miscompares = 0;
	int comparisons = 0;

	// Swapping the end switches fakes a valve that disagrees with its command.
	assign pins = {brk, pwrOk, atClosed ^ fbSwap, atOpen ^ fbSwap, flowOk,
		pumpOk, req};
	always #2 sys_clk = ~sys_clk;

	lthr_seq #(.TICK_CYCLES(TC)) lthr_seq_inst (.sys_clk(sys_clk),
		.nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pins(pins), .temps(temps),
		.externalPower(extPower), .waterPressure(press), .pumpOn(pumpOn),
		.pumpSpeed(pumpSpeed), .valveOpen(valveOpen), .alarms(alarms));
	lthr_field_model lthr_field_model_inst (.sys_clk(sys_clk), .nrst(nrst),
		.valveOpen(valveOpen), .pumpHealthy(pHealthy),
		.flowHealthy(fHealthy), .pumpOk(pumpOk), .flowOk(flowOk),
		.atOpen(atOpen), .atClosed(atClosed));

	////////////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
			output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] q;
		bus(0, lthr_pkg::ADDR_CTRL, 0, q);
		check("ctrl", q, 32'h0000_0002);
		bus(0, lthr_pkg::ADDR_SPREAD, 0, q);
		check("spread", q, 32'h0000_0046);
		bus(0, lthr_pkg::ADDR_PUMP_LIM, 0, q);
		check("pump limits", q, 32'h0000_6414);
		bus(0, lthr_pkg::ADDR_LOCK, 0, q);
		check("lockout", q, 32'h0000_000f);
		bus(0, lthr_pkg::ADDR_HEAT, 0, q);
		check("no power delay", q[31:16], 32'h0000_000a);
		bus(1, 8'h30, 32'h1234_5678, q);
		bus(0, 8'h30, 0, q);
		check("unmapped", q, 32'h0);
		$display("test registers done");
	endtask

	task automatic t_off();
		logic [31:0] q;
		bus(1, lthr_pkg::ADDR_CTRL, 32'h0000_0003, q);
		req <= 1'b1;
		cyc(160 * TC);
		check("pump on, off button", pumpOn, 0);
		req <= 1'b0;
		// The request must be gone before the button clears, or the pump starts.
		cyc(10);
		bus(1, lthr_pkg::ADDR_CTRL, 32'h0000_0002, q);
		check("pump off after release", pumpOn, 0);
		$display("test off button done");
	endtask

	task automatic t_start();
		int n;
		req <= 1'b1;
		cyc(140 * TC);
		check("pump on early", pumpOn, 0);
		n = 0;
		while (pumpOn !== 1'b1 && n < 30 * TC) begin
			cyc(1);
			n++;
		end
		check("pump on", pumpOn, 1);
		check("speed min", pumpSpeed, 8'd20);
		cyc(4);
		check("valve open", valveOpen, 1);
		temps.waterOut <= 16'sd300;
		cyc(90 * TC);
		check("speed max", pumpSpeed, 8'd100);
		temps.waterOut <= 16'sd250;
		cyc(90 * TC);
		check("speed back", pumpSpeed, 8'd20);
		check("mismatch quiet", alarms.valveMismatch, 0);
		fbSwap <= 1'b1;
		cyc(10);
		check("mismatch blanked", alarms.valveMismatch, 0);
		cyc(100 * TC);
		check("mismatch alarm", alarms.valveMismatch, 1);
		fbSwap <= 1'b0;
		cyc(10);
		check("mismatch clear", alarms.valveMismatch, 0);
		$display("test start done");
	endtask

	task automatic t_faults();
		pHealthy <= 1'b0;
		cyc(10);
		check("pump fault", alarms.pumpFault, 1);
		check("pump kept", pumpOn, 1);
		check("valve fault", valveOpen, 0);
		pHealthy <= 1'b1;
		fHealthy <= 1'b0;
		cyc(50 * TC);
		check("valve flow early", valveOpen, 1);
		cyc(15 * TC);
		check("valve flow", valveOpen, 0);
		check("flow alarm", alarms.flowLoss, 1);
		check("pump flow", pumpOn, 1);
		fHealthy <= 1'b1;
		cyc(5 * TC);
		temps.waterOut <= 16'sd410;
		cyc(3 * TC);
		check("over temp", alarms.overTemp, 1);
		check("valve hot", valveOpen, 0);
		temps.waterOut <= 16'sd380;
		cyc(3 * TC);
		check("valve band", valveOpen, 0);
		temps.waterOut <= 16'sd369;
		cyc(3 * TC);
		check("valve rearm", valveOpen, 1);
		temps.waterOut <= 16'sd250;
		for (int i = 0; i < 4; i++) begin
			brk <= 4'h1 << i;
			cyc(10);
			check("wire break", alarms.wireBreak, 1);
			brk <= 4'h0;
			cyc(10);
		end
		$display("test monitors done");
	endtask

	task automatic t_power();
		logic [31:0] q;
		bus(0, lthr_pkg::ADDR_STATUS, 0, q);
		check("power ext", q[15:8], 8'h32);
		bus(1, lthr_pkg::ADDR_CTRL, 32'h0000_0000, q);
		cyc(2);
		bus(0, lthr_pkg::ADDR_STATUS, 0, q);
		check("power int", q[15:8], 8'h64);
		bus(1, lthr_pkg::ADDR_CTRL, 32'h0000_0002, q);
		pwrOk <= 1'b0;
		cyc(10);
		check("valve no power", valveOpen, 0);
		pwrOk <= 1'b1;
		press <= 16'h0064;
		bus(1, lthr_pkg::ADDR_PRESS, 32'h0001_0078, q);
		bus(1, lthr_pkg::ADDR_CTRL, 32'h0000_0006, q);
		cyc(50 * TC);
		check("valve press early", valveOpen, 1);
		cyc(20 * TC);
		check("press alarm", alarms.lowPressure, 1);
		check("valve press", valveOpen, 0);
		check("pump press", pumpOn, 1);
		press <= 16'h00c8;
		bus(1, lthr_pkg::ADDR_CTRL, 32'h0000_0002, q);
		cyc(10);
		check("valve press back", valveOpen, 1);
		$display("test power and pressure done");
	endtask

	task automatic t_lock();
		logic [31:0] q;
		bus(1, lthr_pkg::ADDR_HEAT, 32'h0001_0032, q);
		bus(1, lthr_pkg::ADDR_LOCK, 32'h0000_0001, q);
		temps.gasIn <= 16'sd150;
		cyc(50 * TC);
		check("power delay", alarms.noHeatPower, 0);
		check("valve before lock", valveOpen, 1);
		cyc(20 * TC);
		check("power alarm", alarms.noHeatPower, 1);
		check("valve lock", valveOpen, 0);
		temps.gasIn <= 16'sd700;
		cyc(40 * TC);
		check("lock held", alarms.noHeatPower, 1);
		cyc(40 * TC);
		check("lock over", alarms.noHeatPower, 0);
		check("valve after lock", valveOpen, 1);
		$display("test heating power done");
	endtask

	task automatic t_stop();
		req <= 1'b0;
		cyc(10);
		check("valve stop", valveOpen, 0);
		check("pump run on", pumpOn, 1);
		cyc(140 * TC);
		check("pump overrun", pumpOn, 1);
		cyc(20 * TC);
		check("pump off", pumpOn, 0);
		$display("test stop done");
	endtask

	initial begin
		cyc(4);
		nrst <= 1'b1;
		cyc(10);
		t_regs();
		t_off();
		t_start();
		t_faults();
		t_power();
		t_lock();
		t_stop();
		results();
	end

	initial begin
		cyc(20000);
		miscompares++;
		results();
	end
endmodule
